//--- hw/dtc_timer.v
// Functional notes
// - ext irq b type bit: one means falling edge, zero means low level
// - ext irq a type bit: one means falling edge, zero means low level
// - ext irq a pending flag holds one until its service is done
// - timer b gated: with gate set, counts only while ext irq b pin high
// - timer a gated: with gate set, counts only while ext irq a pin high
// - timer b counter-select one counts external events, else timer
// - timer a counter-select one counts external events, else timer
// - high and low count bytes readable, writable, reset to zero
// - mode 0 counts low 7 high-byte bits and low 5 low-byte bits
// - mode 0 overflow sets that timer's overflow flag
// - mode 1 uses both full bytes as one 16-bit counter
// - mode 2 low byte counts, reloads from high byte, overflow sets flag
// - mode 2 reload leaves the high byte unchanged, both timers
// - mode 3 timer a low byte is 8-bit timer under timer a controls
// - mode 3 timer a high byte runs on timer b run, sets b flag
// - timer a in mode 3 stops timer b and holds its count
// - event inputs sampled every 12 clocks, one-to-zero change counts
// - overflow flag requests interrupt, cleared when service done
// - each timer enabled only while its run bit is one, except timer a high byte in mode 3
// - ext irq b pending flag set while pending, cleared when serviced
//
// Added by the designer: the Avalon-MM slave port.
`include "dtc_defs.vh"

module dtc_timer #(
   parameter SAMPLE_CYCLES = `DTC_SAMPLE_CYCLES
) (
   input wire REF_CLK,
   input wire RST_N,
   input wire [9:0] AVS_ADDRESS,
   input wire AVS_READ,
   input wire AVS_WRITE,
   input wire [31:0] AVS_WRITEDATA,
   input wire [3:0] AVS_BYTEENABLE,
   output wire [31:0] AVS_READDATA,
   output wire AVS_WAITREQUEST,
   input wire EXT_IRQ_A_PIN,
   input wire EXT_IRQ_B_PIN,
   input wire TMR_A_EVENT_INPUT,
   input wire TMR_B_EVENT_INPUT,
   input wire TMR_A_IRQ_DONE,
   input wire TMR_B_IRQ_DONE,
   input wire EXT_IRQ_A_DONE,
   input wire EXT_IRQ_B_DONE,
   output wire TMR_A_IRQ,
   output wire TMR_B_IRQ,
   output wire EXT_IRQ_A_REQ,
   output wire EXT_IRQ_B_REQ
);

   ////////////////////////////////////////////////////////////////////
   // one step of a count pair; returns {overflow, high, low}
   function [16:0] dtc_step;
      input [1:0] mode;
      input [7:0] hi;
      input [7:0] lo;
      input en;
      reg [5:0] lo5;
      reg [7:0] hi7;
      reg [16:0] sum16;
      reg [8:0] lo9;
      begin
         lo5 = {1'b0, lo[4:0]} + 6'h01;
         hi7 = {1'b0, hi[6:0]} + {7'h00, lo5[5]};
         sum16 = {1'b0, hi, lo} + 17'h00001;
         lo9 = {1'b0, lo} + 9'h001;
         dtc_step = {1'b0, hi, lo};
         if (en) begin
            case (mode)
               `DTC_MODE_12BIT: begin
                  // unused top bits stay as written
                  dtc_step = {hi7[7], hi[7], hi7[6:0], lo[7:5], lo5[4:0]};
               end
               `DTC_MODE_16BIT: begin
                  dtc_step = sum16;
               end
               `DTC_MODE_SPLIT: begin
                  // low byte is a plain 8-bit timer, wraps with no reload
                  dtc_step = {lo9[8], hi, lo9[7:0]};
               end
               default: begin
                  // reload keeps the high byte as it is
                  dtc_step = {lo9[8], hi, (lo9[8] ? hi : lo9[7:0])};
               end
            endcase
         end
      end
   endfunction

   ////////////////////////////////////////////////////////////////////
   // pin synchronisers: ext a, ext b, event a, event b
   wire [3:0] pin_raw;
   reg [3:0] sync1_reg;
   reg [3:0] sync2_reg;
   assign pin_raw = {TMR_B_EVENT_INPUT, TMR_A_EVENT_INPUT,
                     EXT_IRQ_B_PIN, EXT_IRQ_A_PIN};

   // one loop body per pin keeps the four synchronisers identical
   genvar gi;
   generate
      for (gi = 0; gi < 4; gi = gi + 1) begin : g_sync
         // two flops, the first read only by the second
         always @(posedge REF_CLK or negedge RST_N) begin
            if (!RST_N) begin
               sync1_reg[gi] <= 1'b1;
               sync2_reg[gi] <= 1'b1;
            end else begin
               sync1_reg[gi] <= pin_raw[gi];
               sync2_reg[gi] <= sync1_reg[gi];
            end
         end
      end
   endgenerate

   // gating and level requests read only the synchronised copies
   wire ext_a_pin = sync2_reg[0];
   wire ext_b_pin = sync2_reg[1];

   ////////////////////////////////////////////////////////////////////
   // divide by the sample period; one-cycle tick
   reg [3:0] div_reg;
   // four-bit divider: the period must stay between 1 and 16 clocks
   localparam integer DIV_LAST = SAMPLE_CYCLES - 1;
   wire [3:0] div_last = DIV_LAST[3:0];
   wire tick = (div_reg == div_last);

   always @(posedge REF_CLK or negedge RST_N) begin
      if (!RST_N) begin
         div_reg <= 4'h0;
      end else if (tick) begin
         div_reg <= 4'h0;
      end else begin
         div_reg <= div_reg + 4'h1;
      end
   end

   // event input samples, taken on the tick only
   // a level held for less than one period may be missed
   reg ev_a_smp_reg;
   reg ev_b_smp_reg;
   wire ev_a_fall = tick & ev_a_smp_reg & ~sync2_reg[2];
   wire ev_b_fall = tick & ev_b_smp_reg & ~sync2_reg[3];

   always @(posedge REF_CLK or negedge RST_N) begin
      if (!RST_N) begin
         ev_a_smp_reg <= 1'b1;
         ev_b_smp_reg <= 1'b1;
      end else if (tick) begin
         ev_a_smp_reg <= sync2_reg[2];
         ev_b_smp_reg <= sync2_reg[3];
      end
   end

   // ext pin edge detect on synchronised levels
   // prev flops reset high, the idle level, so release makes no false edge
   reg ext_a_prev_reg;
   reg ext_b_prev_reg;
   wire ext_a_fall = ext_a_prev_reg & ~ext_a_pin;
   wire ext_b_fall = ext_b_prev_reg & ~ext_b_pin;

   always @(posedge REF_CLK or negedge RST_N) begin
      if (!RST_N) begin
         ext_a_prev_reg <= 1'b1;
         ext_b_prev_reg <= 1'b1;
      end else begin
         ext_a_prev_reg <= ext_a_pin;
         ext_b_prev_reg <= ext_b_pin;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // registers
   reg [7:0] ctrl_reg;
   reg [7:0] mode_reg;
   reg [7:0] a_lo_reg;
   reg [7:0] a_hi_reg;
   reg [7:0] b_lo_reg;
   reg [7:0] b_hi_reg;
   reg ack_reg;
   reg [7:0] rdata_reg;

   // avalon slave: one wait cycle, answer on the second edge
   wire req = AVS_READ | AVS_WRITE;
   assign AVS_WAITREQUEST = req & ~ack_reg;
   assign AVS_READDATA = {24'h000000, rdata_reg};

   // register select, one bit per register; shared by write and read decode
   function [5:0] dtc_sel;
      input [7:0] index;
      input ok;
      begin
         dtc_sel = 6'h00;
         if (ok) begin
            case (index)
               `DTC_IDX_CTRL: dtc_sel = 6'h01;
               `DTC_IDX_MODE: dtc_sel = 6'h02;
               `DTC_IDX_A_LOW: dtc_sel = 6'h04;
               `DTC_IDX_B_LOW: dtc_sel = 6'h08;
               `DTC_IDX_A_HIGH: dtc_sel = 6'h10;
               `DTC_IDX_B_HIGH: dtc_sel = 6'h20;
               default: dtc_sel = 6'h00;
            endcase
         end
      end
   endfunction

   wire word_ok = (AVS_ADDRESS[1:0] == 2'b00);
   wire [7:0] idx = AVS_ADDRESS[9:2];
   wire [5:0] sel = dtc_sel(idx, word_ok);
   wire wr_go = AVS_WRITE & ack_reg & AVS_BYTEENABLE[0];
   wire [7:0] wd = AVS_WRITEDATA[7:0];
   wire wr_ctrl = wr_go & sel[0];
   wire wr_mode = wr_go & sel[1];
   wire wr_a_lo = wr_go & sel[2];
   wire wr_b_lo = wr_go & sel[3];
   wire wr_a_hi = wr_go & sel[4];
   wire wr_b_hi = wr_go & sel[5];

   ////////////////////////////////////////////////////////////////////
   // control field views
   wire tmr_b_run = ctrl_reg[`DTC_CTL_B_RUN];
   wire tmr_a_run = ctrl_reg[`DTC_CTL_A_RUN];
   wire ext_irq_b_type_select = ctrl_reg[`DTC_CTL_EB_TYPE];
   wire ext_irq_a_type_select = ctrl_reg[`DTC_CTL_EA_TYPE];
   wire tmr_b_pin_gating = mode_reg[`DTC_MOD_B_GATE];
   wire tmr_a_pin_gating = mode_reg[`DTC_MOD_A_GATE];
   wire tmr_b_counter_select = mode_reg[`DTC_MOD_B_CNT];
   wire tmr_a_counter_select = mode_reg[`DTC_MOD_A_CNT];
   wire [1:0] tmr_b_mode_field = mode_reg[`DTC_MOD_B_HI:`DTC_MOD_B_LO];
   wire [1:0] tmr_a_mode_field = mode_reg[`DTC_MOD_A_HI:`DTC_MOD_A_LO];
   wire a_split = (tmr_a_mode_field == `DTC_MODE_SPLIT);
   wire b_split = (tmr_b_mode_field == `DTC_MODE_SPLIT);

   // enables: run bit, optional pin gate, then event or tick source
   wire a_gate_ok = ~tmr_a_pin_gating | ext_a_pin;
   wire b_gate_ok = ~tmr_b_pin_gating | ext_b_pin;
   wire a_src = tmr_a_counter_select ? ev_a_fall : tick;
   wire b_src = tmr_b_counter_select ? ev_b_fall : tick;
   wire a_en = tmr_a_run & a_gate_ok & a_src;
   // timer b frozen while a is split, and in its own mode 3
   wire b_en = tmr_b_run & b_gate_ok & b_src & ~a_split & ~b_split;
   // split high byte is always a timer, run by timer b's bit
   wire ah_en = a_split & tmr_b_run & tick;

   // step results
   wire [16:0] a_step = dtc_step(tmr_a_mode_field, a_hi_reg, a_lo_reg, a_en);
   wire [16:0] b_step = dtc_step(tmr_b_mode_field, b_hi_reg, b_lo_reg, b_en);
   wire [8:0] ah_sum = {1'b0, a_hi_reg} + 9'h001;
   wire ah_ovf = ah_en & ah_sum[8];
   wire a_ovf = a_step[16];
   wire b_ovf = b_step[16] | ah_ovf;

   // split mode high byte comes from its own counter
   wire [7:0] a_hi_new = a_split ? (ah_en ? ah_sum[7:0] : a_hi_reg)
                                 : a_step[15:8];

   ////////////////////////////////////////////////////////////////////
   // external interrupt requests
   wire ea_set = ext_irq_a_type_select & ext_a_fall;
   wire eb_set = ext_irq_b_type_select & ext_b_fall;
   wire ea_pend = ctrl_reg[`DTC_CTL_EA_PEND];
   wire eb_pend = ctrl_reg[`DTC_CTL_EB_PEND];
   // level type follows the pin; nothing is latched
   assign EXT_IRQ_A_REQ = ext_irq_a_type_select ? ea_pend : ~ext_a_pin;
   assign EXT_IRQ_B_REQ = ext_irq_b_type_select ? eb_pend : ~ext_b_pin;
   // the overflow flags are the requests, so a done pulse drops them
   assign TMR_A_IRQ = ctrl_reg[`DTC_CTL_A_OVF];
   assign TMR_B_IRQ = ctrl_reg[`DTC_CTL_B_OVF];

   // sticky flag: hardware set wins over write and service clear
   // the set wins so an event in the clearing cycle is never lost
   function flag_next;
      input cur;
      input set;
      input wr;
      input wbit;
      input done;
      begin
         if (set) begin
            flag_next = 1'b1;
         end else if (wr) begin
            flag_next = wbit;
         end else if (done) begin
            flag_next = 1'b0;
         end else begin
            flag_next = cur;
         end
      end
   endfunction

   // a pending bit written as one in level type is dropped below
   reg [7:0] ctrl_next;
   always @* begin
      ctrl_next = wr_ctrl ? wd : ctrl_reg;
      ctrl_next[`DTC_CTL_B_OVF] = flag_next(ctrl_reg[`DTC_CTL_B_OVF], b_ovf,
         wr_ctrl, wd[`DTC_CTL_B_OVF], TMR_B_IRQ_DONE);
      ctrl_next[`DTC_CTL_A_OVF] = flag_next(ctrl_reg[`DTC_CTL_A_OVF], a_ovf,
         wr_ctrl, wd[`DTC_CTL_A_OVF], TMR_A_IRQ_DONE);
      ctrl_next[`DTC_CTL_EB_PEND] = flag_next(eb_pend, eb_set,
         wr_ctrl, wd[`DTC_CTL_EB_PEND], EXT_IRQ_B_DONE);
      ctrl_next[`DTC_CTL_EA_PEND] = flag_next(ea_pend, ea_set,
         wr_ctrl, wd[`DTC_CTL_EA_PEND], EXT_IRQ_A_DONE);
      // a level-type line never holds a latched flag
      if (!ctrl_next[`DTC_CTL_EA_TYPE]) begin
         ctrl_next[`DTC_CTL_EA_PEND] = 1'b0;
      end
      if (!ctrl_next[`DTC_CTL_EB_TYPE]) begin
         ctrl_next[`DTC_CTL_EB_PEND] = 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // state update; a bus write to a count byte overrides its step
   // a 16-bit count read as two bytes may tear while the timer runs
   always @(posedge REF_CLK or negedge RST_N) begin
      if (!RST_N) begin
         ctrl_reg <= `DTC_RESET_BYTE;
         mode_reg <= `DTC_RESET_BYTE;
         a_lo_reg <= `DTC_RESET_BYTE;
         a_hi_reg <= `DTC_RESET_BYTE;
         b_lo_reg <= `DTC_RESET_BYTE;
         b_hi_reg <= `DTC_RESET_BYTE;
      end else begin
         ctrl_reg <= ctrl_next;
         if (wr_mode) begin
            mode_reg <= wd;
         end
         a_lo_reg <= wr_a_lo ? wd : a_step[7:0];
         a_hi_reg <= wr_a_hi ? wd : a_hi_new;
         b_lo_reg <= wr_b_lo ? wd : b_step[7:0];
         b_hi_reg <= wr_b_hi ? wd : b_step[15:8];
      end
   end

   ////////////////////////////////////////////////////////////////////
   // read mux; pending bits show the live request in level type
   reg [7:0] rd_mux;
   always @* begin
      rd_mux = 8'h00;
      case (sel)
         6'h01: begin
            rd_mux = ctrl_reg;
            rd_mux[`DTC_CTL_EA_PEND] = EXT_IRQ_A_REQ;
            rd_mux[`DTC_CTL_EB_PEND] = EXT_IRQ_B_REQ;
         end
         6'h02: rd_mux = mode_reg;
         6'h04: rd_mux = a_lo_reg;
         6'h08: rd_mux = b_lo_reg;
         6'h10: rd_mux = a_hi_reg;
         6'h20: rd_mux = b_hi_reg;
         default: rd_mux = 8'h00;
      endcase
   end

   // bus handshake: data captured in the wait cycle, held after
   // fixed single wait state, the same for every index and direction
   always @(posedge REF_CLK or negedge RST_N) begin
      if (!RST_N) begin
         ack_reg <= 1'b0;
         rdata_reg <= 8'h00;
      end else begin
         ack_reg <= req & ~ack_reg;
         if (AVS_READ & ~ack_reg) begin
            rdata_reg <= rd_mux;
         end
      end
   end

endmodule // dtc_timer

//--- hw/dtc_defs.vh
`ifndef DTC_DEFS_VH
`define DTC_DEFS_VH

// register indices; byte address is four times the index
`define DTC_IDX_CTRL 8'h88
`define DTC_IDX_MODE 8'h89
`define DTC_IDX_A_LOW 8'h8a
`define DTC_IDX_B_LOW 8'h8b
`define DTC_IDX_A_HIGH 8'h8c
`define DTC_IDX_B_HIGH 8'h8d

// reset value of every register
`define DTC_RESET_BYTE 8'h00

// timer_and_irq_control bit positions
`define DTC_CTL_B_OVF 7
`define DTC_CTL_B_RUN 6
`define DTC_CTL_A_OVF 5
`define DTC_CTL_A_RUN 4
`define DTC_CTL_EB_PEND 3
`define DTC_CTL_EB_TYPE 2
`define DTC_CTL_EA_PEND 1
`define DTC_CTL_EA_TYPE 0

// timer_mode_control bit positions
`define DTC_MOD_B_GATE 7
`define DTC_MOD_B_CNT 6
`define DTC_MOD_B_HI 5
`define DTC_MOD_B_LO 4
`define DTC_MOD_A_GATE 3
`define DTC_MOD_A_CNT 2
`define DTC_MOD_A_HI 1
`define DTC_MOD_A_LO 0

// mode encodings
`define DTC_MODE_12BIT 2'h0
`define DTC_MODE_16BIT 2'h1
`define DTC_MODE_RELOAD 2'h2
`define DTC_MODE_SPLIT 2'h3

// system clocks between samples of the event inputs
`define DTC_SAMPLE_CYCLES 12

`endif

//--- tb/dtc_timer_properties.sv
module dtc_props (
   input wire logic REF_CLK,
   input wire logic RST_N,
   input wire logic [9:0] AVS_ADDRESS,
   input wire logic AVS_READ,
   input wire logic AVS_WRITE,
   input wire logic [31:0] AVS_WRITEDATA,
   input wire logic [31:0] AVS_READDATA,
   input wire logic AVS_WAITREQUEST,
   input wire logic EXT_IRQ_A_PIN,
   input wire logic EXT_IRQ_B_PIN,
   input wire logic EXT_IRQ_A_DONE,
   input wire logic TMR_A_IRQ_DONE,
   input wire logic TMR_A_IRQ,
   input wire logic EXT_IRQ_A_REQ,
   input wire logic EXT_IRQ_B_REQ
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge REF_CLK);
   endclocking
   default disable iff (!RST_N);
   logic [7:0] ctl_reg;
   logic ctl_wr;
   logic req;
   // shadow of the control byte so the type bits are known here
   assign req = AVS_READ || AVS_WRITE;
   assign ctl_wr = AVS_WRITE && !AVS_WAITREQUEST && AVS_ADDRESS == 10'h220;
   always @(posedge REF_CLK or negedge RST_N) begin
      if (!RST_N)
         ctl_reg <= 8'h00;
      else if (ctl_wr)
         ctl_reg <= AVS_WRITEDATA[7:0];
   end
   ////////////////////////////////////////////////////////////////////////////
   a_wait_once: assert property (req && AVS_WAITREQUEST |=> !AVS_WAITREQUEST)
      else $error("request waited more than one cycle");
   a_new_req_waits: assert property (req && !$past(req) |-> AVS_WAITREQUEST)
      else $error("new request not held for a cycle");
   a_rdata_upper: assert property (AVS_READDATA[31:8] == 24'h0)
      else $error("read data upper lanes not zero");
   a_level_a: assert property (!ctl_reg[0] |-> EXT_IRQ_A_REQ == !$past(EXT_IRQ_A_PIN, 2))
      else $error("level request a does not follow pin");
   a_level_b: assert property (!ctl_reg[2] |-> EXT_IRQ_B_REQ == !$past(EXT_IRQ_B_PIN, 2))
      else $error("level request b does not follow pin");
   a_edge_a_set: assert property (ctl_reg[0] && $fell(EXT_IRQ_A_PIN) |-> ##3 EXT_IRQ_A_REQ)
      else $error("falling edge a not latched");
   a_edge_b_set: assert property (ctl_reg[2] && $fell(EXT_IRQ_B_PIN) |-> ##3 EXT_IRQ_B_REQ)
      else $error("falling edge b not latched");
   a_done_clears: assert property ((ctl_reg[0] && EXT_IRQ_A_PIN)[*4] ##0 EXT_IRQ_A_DONE
      |=> !EXT_IRQ_A_REQ)
      else $error("pending a not cleared by service");
   a_ovf_holds: assert property (TMR_A_IRQ && !TMR_A_IRQ_DONE && !ctl_wr |=> TMR_A_IRQ)
      else $error("overflow flag a dropped");
   a_ctl_read: assert property (AVS_READ && !AVS_WAITREQUEST && AVS_ADDRESS == 10'h220
      |-> AVS_READDATA[5] == $past(TMR_A_IRQ) && AVS_READDATA[1] == $past(EXT_IRQ_A_REQ))
      else $error("control read does not show flags");
endmodule // dtc_props

bind dtc_timer dtc_props u_props (.REF_CLK(REF_CLK), .RST_N(RST_N), .AVS_ADDRESS(AVS_ADDRESS),
   .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE), .AVS_WRITEDATA(AVS_WRITEDATA),
   .AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST),
   .EXT_IRQ_A_PIN(EXT_IRQ_A_PIN), .EXT_IRQ_B_PIN(EXT_IRQ_B_PIN),
   .EXT_IRQ_A_DONE(EXT_IRQ_A_DONE), .TMR_A_IRQ_DONE(TMR_A_IRQ_DONE), .TMR_A_IRQ(TMR_A_IRQ),
   .EXT_IRQ_A_REQ(EXT_IRQ_A_REQ), .EXT_IRQ_B_REQ(EXT_IRQ_B_REQ));

//--- tb/dtc_core_model.sv
module dtc_core_model (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic serve_en,
   input wire logic [3:0] delay,
   input wire logic [3:0] irq,
   output logic [3:0] done
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [3:0] cnt_reg;
   // the core needs a while to reach its handlers, then reports them done at once
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_reg <= 4'h0;
         done <= 4'h0;
      end else begin
         done <= 4'h0;
         if (!serve_en || irq == 4'h0)
            cnt_reg <= 4'h0;
         else if (cnt_reg < delay)
            cnt_reg <= cnt_reg + 4'h1;
         else begin
            done <= irq; // one-cycle completion pulses
            cnt_reg <= 4'h0;
         end
      end
   end
endmodule // dtc_core_model

//--- tb/test_dual_timer_counter_ext_irq.sv
module test_dual_timer_counter_ext_irq;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk, rst_n, rd, wr, serve;
   logic [1:0] pin, ev;
   logic [9:0] addr;
   logic [31:0] wdata;
   logic [7:0] rv, v, g;
   logic [3:0] dly;
   logic [16:0] e;
   wire [31:0] rdata;
   wire [3:0] irq, done;
   wire wreq;
   int err_count, checked, seed, k, n;
   dtc_timer #(.SAMPLE_CYCLES(12)) dut (.REF_CLK(clk), .RST_N(rst_n), .AVS_ADDRESS(addr),
      .AVS_READ(rd), .AVS_WRITE(wr), .AVS_WRITEDATA(wdata), .AVS_BYTEENABLE(4'h1),
      .AVS_READDATA(rdata), .AVS_WAITREQUEST(wreq), .EXT_IRQ_A_PIN(pin[0]),
      .EXT_IRQ_B_PIN(pin[1]), .TMR_A_EVENT_INPUT(ev[0]), .TMR_B_EVENT_INPUT(ev[1]),
      .TMR_A_IRQ_DONE(done[0]), .TMR_B_IRQ_DONE(done[1]), .EXT_IRQ_A_DONE(done[2]),
      .EXT_IRQ_B_DONE(done[3]), .TMR_A_IRQ(irq[0]), .TMR_B_IRQ(irq[1]),
      .EXT_IRQ_A_REQ(irq[2]), .EXT_IRQ_B_REQ(irq[3]));
   dtc_core_model core (.clk(clk), .rst_n(rst_n), .serve_en(serve), .delay(dly), .irq(irq),
      .done(done));
   ////////////////////////////////////////////////////////////////////////////
   // free-running system clock
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   task automatic stop_test();
      $display("errors %0d checks %0d", err_count, checked);
      if (err_count == 0 && checked > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   task automatic chk(string nm, logic [7:0] x, logic [7:0] s);
      checked++;
      if (s !== x) begin
         $display("ERROR %s expected %h seen %h", nm, x, s);
         err_count++;
      end
   endtask
   // one bus access; an edge passes first so a released strobe is never re-raised at once
   task automatic bus(logic w, logic [9:0] a, logic [7:0] d);
      int c;
      @(posedge clk);
      wr <= w;
      rd <= !w;
      addr <= a;
      wdata <= {24'h0, d};
      c = 0;
      do begin
         @(posedge clk);
         c++;
      end while (wreq !== 1'b0 && c < 50);
      if (c >= 50) begin
         chk("waitrequest", 8'h0, {7'h0, wreq});
         stop_test();
      end
      rv = rdata[7:0];
      wr <= 1'b0;
      rd <= 1'b0;
   endtask
   // flag, high and low byte after one count step from all ones
   function automatic logic [16:0] one_step(int t, int m);
      case (m)
         0: return {1'b1, 16'h80e0};
         1: return {1'b1, 16'h0000};
         2: return {1'b1, 16'hffff};
         default: return t ? {1'b0, 16'hffff} : {1'b1, 16'hff00};
      endcase
   endfunction
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      seed = 50029;
      {rd, wr, serve} = 3'h0;
      pin = 2'h3;
      ev = 2'h3;
      addr = 10'h0;
      wdata = 32'h0;
      dly = 4'h2;
      err_count = 0;
      checked = 0;
      rst_n = 1'b0;
      repeat (8) @(posedge clk);
      rst_n <= 1'b1;
      for (int i = 0; i < 6; i++) begin
         bus(0, 10'h220 + 10'(4 * i), 8'h0);
         chk("reset_value", 8'h00, rv);
      end
      bus(1, 10'h23c, 8'h5a);
      bus(0, 10'h23c, 8'h0);
      chk("unmapped", 8'h00, rv);
      for (int i = 1; i < 6; i++) begin
         v = 8'($random(seed));
         bus(1, 10'h220 + 10'(4 * i), v);
         bus(0, 10'h220 + 10'(4 * i), 8'h0);
         chk("readback", v, rv);
      end
      // every mode, each timer: gate held shut by low pins, opened for exactly 12 edges
      pin <= 2'h0;
      for (int t = 0; t < 2; t++) begin
         for (int m = 0; m < 4; m++) begin
            g = t ? 8'h80 : 8'h08;
            bus(1, 10'h220, t ? 8'h40 : 8'h10);
            bus(1, 10'h224, g | 8'(m << (4 * t)));
            bus(1, 10'h228 + 10'(4 * t), 8'hff);
            bus(1, 10'h230 + 10'(4 * t), 8'hff);
            bus(1, 10'h224, 8'(m << (4 * t)));
            repeat (9) @(posedge clk);
            bus(1, 10'h224, g | 8'(m << (4 * t)));
            e = one_step(t, m);
            #1 chk("ovf_flag", {7'h0, e[16]}, {7'h0, irq[t]});
            bus(0, 10'h228 + 10'(4 * t), 8'h0);
            chk("count_low", e[7:0], rv);
            bus(0, 10'h230 + 10'(4 * t), 8'h0);
            chk("count_high", e[15:8], rv);
         end
      end
      // split mode: high byte of timer a runs on timer b run, timer b frozen
      bus(1, 10'h224, 8'h1b);
      bus(1, 10'h22c, 8'h33);
      bus(1, 10'h230, 8'hfe);
      bus(1, 10'h220, 8'h40);
      repeat (40) @(posedge clk);
      #1 chk("split_ovf", 8'h01, {7'h0, irq[1]});
      bus(0, 10'h22c, 8'h0);
      chk("held_count", 8'h33, rv);
      pin <= 2'h3;
      // event counting: random spacing, each level longer than the sample period
      for (int t = 0; t < 2; t++) begin
         bus(1, 10'h224, t ? 8'h50 : 8'h05);
         bus(1, 10'h228 + 10'(4 * t), 8'h00);
         bus(1, 10'h220, t ? 8'h40 : 8'h10);
         n = 3 + ($unsigned($random(seed)) % 6);
         for (int p = 0; p < n; p++) begin
            ev[t] <= 1'b0;
            repeat (13 + ($unsigned($random(seed)) % 20)) @(posedge clk);
            ev[t] <= 1'b1;
            repeat (13 + ($unsigned($random(seed)) % 20)) @(posedge clk);
         end
         bus(1, 10'h220, 8'h00);
         bus(0, 10'h228 + 10'(4 * t), 8'h0);
         chk("event_count", 8'(n), rv);
      end
      // external requests: level follows pin, edge latches until serviced
      for (int j = 0; j < 2; j++) begin
         bus(1, 10'h220, 8'h00);
         pin[j] <= 1'b0;
         repeat (4) @(posedge clk);
         #1 chk("level_req", 8'h01, {7'h0, irq[2 + j]});
         pin[j] <= 1'b1;
         repeat (4) @(posedge clk);
         #1 chk("level_off", 8'h00, {7'h0, irq[2 + j]});
         bus(1, 10'h220, j ? 8'h04 : 8'h01);
         pin[j] <= 1'b0;
         repeat (4) @(posedge clk);
         pin[j] <= 1'b1;
         repeat (4) @(posedge clk);
         #1 chk("edge_pend", 8'h01, {7'h0, irq[2 + j]});
         dly = 4'(1 + ($unsigned($random(seed)) % 8));
         serve = 1'b1;
         k = 0;
         while (irq[2 + j] !== 1'b0 && k < 30) begin
            @(posedge clk);
            #1 k++;
         end
         chk("pend_clear", 8'h00, {7'h0, irq[2 + j]});
         serve = 1'b0;
      end
      stop_test();
   end
endmodule // test_dual_timer_counter_ext_irq
